/* core/polling_wakeup_timer.sv */
/*
 * polling wakeup timer: interval counter, wake action sequencing and
 * receive flag preload, with a small local register port.
 * assumes register port signals are on ref_clk; reset_state_pin is a pin.
 */
// Operation
// - period is interval value plus one, times the wake tick period
// - extended range select bit chooses normal or extended tick resolution
// - new interval not below counter: running period continues, new value applies
// - new interval below counter content: counter resets at once
// - after wakeup, enter mode from two-bit post-wake field of action register
// - automatic gain field maps onto gain step and gain switch flags
// - command bit: 0 selects wakeup search, 1 preamble detection
// - automatic channel field maps onto the two channel select flags
// - load bit 0 keeps receive flags; 1 overwrites them before launch
// - overwriting receive flags also sets the sub-command flag to one
// - wakeup intervals above 10 ms stay accurate better than one percent
// - every timer overflow raises an interrupt request
// - calibrated tick has a nominal period of 62.5 microseconds
// - timer runs only with oscillator enable; reset-state pin sets it
// - selected wake event releases power-down and enters receive state
`timescale 1ns/100ps
`default_nettype none

module polling_wakeup_timer #(
    parameter int TICK_CYCLES = poll_timer_pkg::TICK_CYCLES,
    parameter int EXT_MULT    = poll_timer_pkg::EXT_MULT_DEF
) (
    // clock, reset, enable
    input  wire logic                               ref_clk,
    input  wire logic                               arst_n,
    input  wire logic                               ce,
    // strap pin
    input  wire logic                               reset_state_pin,
    // register write
    input  wire logic                               reg_wr_en,
    input  wire logic [poll_timer_pkg::SEL_W-1:0]   reg_wr_sel,
    input  wire logic [7:0]                         reg_wr_data,
    // register read
    input  wire logic [poll_timer_pkg::SEL_W-1:0]   reg_rd_sel,
    output logic      [7:0]                         reg_rd_data,
    // wake outputs
    output logic                                    irq_req,
    output logic                                    wake_event,
    output logic      [1:0]                         op_mode,
    output logic                                    pd_release,
    // receive command
    output logic      [poll_timer_pkg::RXF_W-1:0]   rx_flags,
    output logic                                    rx_cmd_launch
);

    // shorter dividers leave no room for the wrap compare
    if (TICK_CYCLES < 2 || EXT_MULT < 2)
    begin
        $error("polling_wakeup_timer: TICK_CYCLES and EXT_MULT must be at least 2");
    end

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_LAUNCH
    } seq_t;

    typedef struct packed {
        logic [7:0]                       interval;
        logic [7:0]                       action;
        logic                             ext_sel;
        logic                             osc_en;
        logic [poll_timer_pkg::RXF_W-1:0] rx_flags;
        logic [7:0]                       count;
        seq_t                             seq;
        logic [1:0]                       strap_cnt;
        logic                             strap_done;
        logic                             irq;
        logic                             wake;
        logic                             launch;
        logic                             release_pd;
        logic [1:0]                       mode;
        logic [7:0]                       rd_data;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic strap_lvl;
    logic tick;

    sync2 u_strap_sync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .d       (reset_state_pin),
        .q       (strap_lvl)
    );

    tick_gen #(
        .TICK_CYCLES (TICK_CYCLES),
        .EXT_MULT    (EXT_MULT)
    ) u_tick (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .run     (s_q.osc_en),
        .ext_sel (s_q.ext_sel),
        .tick    (tick)
    );

    always_comb
    begin
        s_d = s_q;
        if (ce)
        begin
            s_d.irq        = 1'b0;
            s_d.wake       = 1'b0;
            s_d.launch     = 1'b0;
            s_d.release_pd = 1'b0;

            // strap caught only once the synchroniser holds a clean level
            if (!s_q.strap_done)
            begin
                if (s_q.strap_cnt == poll_timer_pkg::STRAP_WAIT)
                begin
                    s_d.osc_en     = strap_lvl;
                    s_d.strap_done = 1'b1;
                end
                else
                    s_d.strap_cnt = s_q.strap_cnt + 2'h1;
            end

            // interval counter
            if (!s_q.osc_en)
                s_d.count = '0;
            else if (tick)
            begin
                if (s_q.count >= s_q.interval)
                begin
                    s_d.count = '0;
                    s_d.wake  = 1'b1;
                    s_d.irq   = 1'b1;
                end
                else
                    s_d.count = s_q.count + 8'h01;
            end

            // software writes
            if (reg_wr_en)
            begin
                case (reg_wr_sel)
                    poll_timer_pkg::REG_INTERVAL:
                    begin
                        s_d.interval = reg_wr_data;
                        if (reg_wr_data < s_q.count)
                            s_d.count = '0;
                    end
                    poll_timer_pkg::REG_ACTION:
                        s_d.action = reg_wr_data;
                    poll_timer_pkg::REG_CLKCON:
                        s_d.ext_sel = reg_wr_data[poll_timer_pkg::CLKCON_EXT_BIT];
                    poll_timer_pkg::REG_PWRMODE:
                        s_d.osc_en = reg_wr_data[poll_timer_pkg::PWR_OSC_EN_BIT];
                    poll_timer_pkg::REG_RXFLAGS:
                        // a preload in the same cycle overrides this below
                        s_d.rx_flags = reg_wr_data[poll_timer_pkg::RXF_W-1:0];
                    default:
                        s_d.rd_data = s_d.rd_data;
                endcase
            end

            // wake action sequence
            case (s_q.seq)
                ST_IDLE:
                begin
                    if (s_q.wake)
                    begin
                        s_d.mode = s_q.action[poll_timer_pkg::ACT_MODE_HI:poll_timer_pkg::ACT_MODE_LO];
                        if (s_q.action[poll_timer_pkg::ACT_LOAD])
                            s_d.seq = ST_LOAD;
                        else
                            s_d.seq = ST_LAUNCH;
                    end
                end
                ST_LOAD:
                begin
                    s_d.rx_flags[poll_timer_pkg::RXF_GAIN_STEP] =
                        s_q.action[poll_timer_pkg::ACT_GAIN_STEP];
                    s_d.rx_flags[poll_timer_pkg::RXF_GAIN_SW] =
                        s_q.action[poll_timer_pkg::ACT_GAIN_SW];
                    s_d.rx_flags[poll_timer_pkg::RXF_CMD_KIND] =
                        s_q.action[poll_timer_pkg::ACT_CMD];
                    s_d.rx_flags[poll_timer_pkg::RXF_CHAN_LO] =
                        s_q.action[poll_timer_pkg::ACT_CHAN_LO];
                    s_d.rx_flags[poll_timer_pkg::RXF_CHAN_HI] =
                        s_q.action[poll_timer_pkg::ACT_CHAN_HI];
                    s_d.rx_flags[poll_timer_pkg::RXF_SUB_CMD] =
                        poll_timer_pkg::SUB_CMD_SEARCH;
                    s_d.seq = ST_LAUNCH;
                end
                ST_LAUNCH:
                begin
                    // the receive command is only issued for a receive mode
                    if (s_q.mode == poll_timer_pkg::MODE_RX)
                    begin
                        s_d.launch     = 1'b1;
                        s_d.release_pd = 1'b1;
                    end
                    s_d.seq = ST_IDLE;
                end
                default:
                    s_d.seq = ST_IDLE;
            endcase

            // registered read data
            case (reg_rd_sel)
                poll_timer_pkg::REG_INTERVAL:
                    s_d.rd_data = s_q.interval;
                poll_timer_pkg::REG_ACTION:
                    s_d.rd_data = s_q.action;
                poll_timer_pkg::REG_CLKCON:
                    s_d.rd_data = {7'h00, s_q.ext_sel};
                poll_timer_pkg::REG_PWRMODE:
                    s_d.rd_data = {7'h00, s_q.osc_en};
                poll_timer_pkg::REG_RXFLAGS:
                    s_d.rd_data = {2'h0, s_q.rx_flags};
                poll_timer_pkg::REG_COUNT:
                    s_d.rd_data = s_q.count;
                poll_timer_pkg::REG_STATUS:
                    s_d.rd_data = {6'h00, (s_q.seq != ST_IDLE), s_q.osc_en};
                default:
                    s_d.rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q            <= '0;
            s_q.interval   <= poll_timer_pkg::INTERVAL_RST;
            s_q.action     <= poll_timer_pkg::ACTION_RST;
            s_q.rx_flags   <= poll_timer_pkg::RXFLAGS_RST;
            s_q.mode       <= poll_timer_pkg::MODE_POWERDOWN;
            s_q.seq        <= ST_IDLE;
        end
        else
            s_q <= s_d;
    end

    // outputs
    assign reg_rd_data   = s_q.rd_data;
    assign irq_req       = s_q.irq;
    assign wake_event    = s_q.wake;
    assign op_mode       = s_q.mode;
    assign pd_release    = s_q.release_pd;
    assign rx_flags      = s_q.rx_flags;
    assign rx_cmd_launch = s_q.launch;

endmodule

`default_nettype wire

/* core/sync2.sv */
/*
 * two-flop synchroniser for one level.
 * assumes d is asynchronous to clk; only q may be read.
 */
`timescale 1ns/100ps
`default_nettype none

module sync2 (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic ce,
    // level
    input  wire logic d,
    output logic      q
);

    typedef struct packed {
        logic s1;
        logic s2;
    } sync_t;

    sync_t s_q;
    sync_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (ce)
        begin
            s_d.s1 = d;
            s_d.s2 = s_q.s1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign q = s_q.s2;

endmodule

`default_nettype wire

/* core/tick_gen.sv */
/*
 * calibrated tick source: divides ref_clk to the wake tick period,
 * with an extra divider for the extended range.
 * assumes run and ext_sel come from logic on ref_clk.
 */
`timescale 1ns/100ps
`default_nettype none

module tick_gen #(
    parameter int TICK_CYCLES = poll_timer_pkg::TICK_CYCLES,
    parameter int EXT_MULT    = poll_timer_pkg::EXT_MULT_DEF
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic ce,
    // control
    input  wire logic run,
    input  wire logic ext_sel,
    // tick pulse
    output logic      tick
);

    localparam int PW = $clog2(TICK_CYCLES);
    localparam int EW = $clog2(EXT_MULT);

    // a one-cycle divider would need zero-width counters
    if (TICK_CYCLES < 2 || EXT_MULT < 2)
    begin
        $error("tick_gen: TICK_CYCLES and EXT_MULT must be at least 2");
    end

    typedef struct packed {
        logic [PW-1:0] pre;
        logic [EW-1:0] ext;
        logic          tick;
    } tick_t;

    tick_t s_q;
    tick_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (ce)
        begin
            s_d.tick = 1'b0;
            if (!run)
            begin
                s_d.pre = '0;
                s_d.ext = '0;
            end
            else if (s_q.pre == PW'(TICK_CYCLES - 1))
            begin
                // exact integer division keeps long intervals well inside 1 %
                s_d.pre = '0;
                if (!ext_sel || s_q.ext == EW'(EXT_MULT - 1))
                begin
                    s_d.tick = 1'b1;
                    s_d.ext  = '0;
                end
                else
                    s_d.ext = s_q.ext + EW'(1);
            end
            else
                s_d.pre = s_q.pre + PW'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign tick = s_q.tick;

endmodule

`default_nettype wire

/* pkg/poll_timer_pkg.sv */
/*
 * constants for the polling wakeup timer: register indices of the local
 * register port, field layouts, reset values and tick timing.
 * assumes a 100 MHz ref_clk and a 3-bit register select.
 */
`default_nettype none

package poll_timer_pkg;

    // register select width and indices
    localparam int          SEL_W          = 3;
    localparam logic [2:0]  REG_INTERVAL   = 3'h0;
    localparam logic [2:0]  REG_ACTION     = 3'h1;
    localparam logic [2:0]  REG_CLKCON     = 3'h2;
    localparam logic [2:0]  REG_PWRMODE    = 3'h3;
    localparam logic [2:0]  REG_RXFLAGS    = 3'h4;
    localparam logic [2:0]  REG_COUNT      = 3'h5;
    localparam logic [2:0]  REG_STATUS     = 3'h6;

    // wake action field positions
    localparam int          ACT_MODE_LO    = 0;
    localparam int          ACT_MODE_HI    = 1;
    localparam int          ACT_GAIN_STEP  = 2;
    localparam int          ACT_GAIN_SW    = 3;
    localparam int          ACT_CMD        = 4;
    localparam int          ACT_CHAN_LO    = 5;
    localparam int          ACT_CHAN_HI    = 6;
    localparam int          ACT_LOAD       = 7;

    // receive flag positions
    localparam int          RXF_CHAN_LO    = 0;
    localparam int          RXF_CHAN_HI    = 1;
    localparam int          RXF_CMD_KIND   = 2;
    localparam int          RXF_SUB_CMD    = 3;
    localparam int          RXF_GAIN_STEP  = 4;
    localparam int          RXF_GAIN_SW    = 5;
    localparam int          RXF_W          = 6;

    // single-bit control fields
    localparam int          CLKCON_EXT_BIT = 0;
    localparam int          PWR_OSC_EN_BIT = 0;
    localparam int          STAT_RUN_BIT   = 0;
    localparam int          STAT_BUSY_BIT  = 1;

    // post-wake modes
    localparam logic [1:0]  MODE_POWERDOWN = 2'h0;
    localparam logic [1:0]  MODE_RX        = 2'h3;

    // command kind encodings
    localparam logic        CMD_WAKEUP_SEARCH = 1'b0;
    localparam logic        CMD_PREAMBLE_DET  = 1'b1;
    localparam logic        SUB_CMD_SEARCH    = 1'b1;

    // reset values
    localparam logic [7:0]  INTERVAL_RST   = 8'hff;
    localparam logic [7:0]  ACTION_RST     = 8'h00;
    localparam logic [5:0]  RXFLAGS_RST    = 6'h00;

    // timing
    localparam real         TICK_PERIOD_US = 62.5;
    localparam real         CLK_PERIOD_NS  = 10.0;
    localparam int          TICK_CYCLES    = int'(TICK_PERIOD_US * 1000.0 / CLK_PERIOD_NS);
    localparam int          EXT_MULT_DEF   = 8;
    localparam logic [1:0]  STRAP_WAIT     = 2'h3;

endpackage

`default_nettype wire

/* tb/poll_timer_assertions.sv */
/*
 * port checker for the polling wakeup timer, bound to its top module.
 * assumes the action register changes only through the write port.
 */
`timescale 1ns/100ps
`default_nettype none

module poll_timer_assertions #(
    parameter int TICK_CYCLES = 4,
    parameter int EXT_MULT    = 2
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    // register port
    input  wire logic       reg_wr_en,
    input  wire logic [2:0] reg_wr_sel,
    input  wire logic [7:0] reg_wr_data,
    // wake outputs
    input  wire logic       irq_req,
    input  wire logic       wake_event,
    input  wire logic [1:0] op_mode,
    input  wire logic       pd_release,
    input  wire logic [5:0] rx_flags,
    input  wire logic       rx_cmd_launch
);
    logic [7:0] act_q;
    logic       mode_rx;
    logic [5:0] exp_flags;

    // shadow of the action register, which sets the mode and flags of the wake sequence
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            act_q <= poll_timer_pkg::ACTION_RST;
        else if (ce && reg_wr_en && reg_wr_sel == poll_timer_pkg::REG_ACTION)
            act_q <= reg_wr_data;
    end

    assign mode_rx   = act_q[1:0] == poll_timer_pkg::MODE_RX;
    assign exp_flags = {act_q[3], act_q[2], 1'b1, act_q[4], act_q[6], act_q[5]};

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    AST_IRQ_WAKE: assert property (irq_req == wake_event)
        else $error("irq request and wake event differ");
    AST_WAKE_GAP: assert property (wake_event |=> !wake_event [*3])
        else $error("wake events closer than one tick");
    AST_MODE: assert property (wake_event |=> op_mode == act_q[1:0])
        else $error("post-wake mode not taken from action");
    AST_LOAD: assert property (wake_event && act_q[7] && mode_rx |-> ##2 rx_flags == exp_flags)
        else $error("receive flags not loaded from action");
    AST_LAUNCH_LOAD: assert property (wake_event && act_q[7] && mode_rx |-> ##3 (rx_cmd_launch && pd_release))
        else $error("loaded launch missing");
    AST_LAUNCH_KEEP: assert property (wake_event && !act_q[7] && mode_rx |-> ##2 rx_cmd_launch ##1 !rx_cmd_launch)
        else $error("plain launch missing or long");
    AST_NO_LAUNCH: assert property (wake_event && !mode_rx |=> !rx_cmd_launch [*3])
        else $error("launch without receive mode");
    AST_PD_PAIR: assert property (pd_release |-> rx_cmd_launch && op_mode == poll_timer_pkg::MODE_RX)
        else $error("power-down release without receive launch");
endmodule

bind polling_wakeup_timer poll_timer_assertions #(
    .TICK_CYCLES(TICK_CYCLES),
    .EXT_MULT   (EXT_MULT)
) chk (
    .ref_clk      (ref_clk),
    .arst_n       (arst_n),
    .ce           (ce),
    .reg_wr_en    (reg_wr_en),
    .reg_wr_sel   (reg_wr_sel),
    .reg_wr_data  (reg_wr_data),
    .irq_req      (irq_req),
    .wake_event   (wake_event),
    .op_mode      (op_mode),
    .pd_release   (pd_release),
    .rx_flags     (rx_flags),
    .rx_cmd_launch(rx_cmd_launch)
);

`default_nettype wire

/* tb/polling_wakeup_timer_tb.sv */
/*
 * self-checking bench for the polling wakeup timer.
 * assumes short tick parameters; strap pin low at first so the timer starts off.
 */
`timescale 1ns/100ps
`default_nettype none

module polling_wakeup_timer_tb;
    localparam int TC = 4;
    localparam int EM = 2;

    logic       ref_clk;
    logic       arst_n;
    logic       ce;
    logic       reset_state_pin;
    logic       reg_wr_en;
    logic [2:0] reg_wr_sel;
    logic [7:0] reg_wr_data;
    logic [2:0] reg_rd_sel;
    logic [7:0] reg_rd_data;
    logic       irq_req;
    logic       wake_event;
    logic [1:0] op_mode;
    logic       pd_release;
    logic [5:0] rx_flags;
    logic       rx_cmd_launch;
    int         n_errors;
    int         checks;
    int         cyc;
    int         n;
    int         m;

    polling_wakeup_timer #(.TICK_CYCLES(TC), .EXT_MULT(EM)) uut (
        .ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .reset_state_pin(reset_state_pin),
        .reg_wr_en(reg_wr_en), .reg_wr_sel(reg_wr_sel), .reg_wr_data(reg_wr_data),
        .reg_rd_sel(reg_rd_sel), .reg_rd_data(reg_rd_data), .irq_req(irq_req),
        .wake_event(wake_event), .op_mode(op_mode), .pd_release(pd_release),
        .rx_flags(rx_flags), .rx_cmd_launch(rx_cmd_launch)
    );

    always #5 ref_clk = ~ref_clk;

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_errors++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [2:0] sel, input logic [7:0] data);
        @(negedge ref_clk);
        reg_wr_en = 1'b1;
        reg_wr_sel = sel;
        reg_wr_data = data;
        @(negedge ref_clk);
        reg_wr_en = 1'b0;
    endtask

    // read data is registered: one cycle after the select is sampled
    task automatic rdchk(input string what, input logic [2:0] sel, input logic [7:0] exp);
        @(negedge ref_clk);
        reg_rd_sel = sel;
        @(negedge ref_clk);
        check(what, exp, reg_rd_data);
    endtask

    // counts cycles up to and including the next wake pulse
    task automatic wait_wake(output int cnt);
        cnt = 0;
        do
        begin
            @(negedge ref_clk);
            cnt++;
        end
        while (wake_event !== 1'b1 && cnt < 1000);
    endtask

    // wake sequence: mode at c1, flags at c2, launch at c2 or c3 (lc), none if lc is 0
    task automatic walk(input logic [7:0] act, input logic [5:0] flags, input int lc);
        wr(poll_timer_pkg::REG_ACTION, act);
        wait_wake(n);
        check("irq", 8'h01, {7'h00, irq_req});
        @(negedge ref_clk);
        check("op_mode", {6'h00, act[1:0]}, {6'h00, op_mode});
        for (int c = 2; c <= 3; c++)
        begin
            @(negedge ref_clk);
            if (c == 2)
                check("rx_flags", {2'h0, flags}, {2'h0, rx_flags});
            check("launch", {7'h00, lc == c}, {7'h00, rx_cmd_launch});
            check("pd_release", {7'h00, lc == c}, {7'h00, pd_release});
        end
    endtask

    initial
    begin
        ref_clk = 1'b0;
        arst_n = 1'b0;
        ce = 1'b1;
        reset_state_pin = 1'b0;
        reg_wr_en = 1'b0;
        reg_wr_sel = 3'h0;
        reg_wr_data = 8'h00;
        reg_rd_sel = 3'h0;
        n_errors = 0;
        checks = 0;
        cyc = 0;
        repeat (10) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (6) @(negedge ref_clk);

        rdchk("interval", poll_timer_pkg::REG_INTERVAL, poll_timer_pkg::INTERVAL_RST);
        rdchk("action", poll_timer_pkg::REG_ACTION, poll_timer_pkg::ACTION_RST);
        rdchk("rxflags", poll_timer_pkg::REG_RXFLAGS, 8'h00);
        rdchk("status", poll_timer_pkg::REG_STATUS, 8'h00);
        rdchk("unmapped", 3'h7, 8'h00);
        repeat (4 * TC) @(negedge ref_clk);
        rdchk("count idle", poll_timer_pkg::REG_COUNT, 8'h00);
        $display("test reset done");

        wr(poll_timer_pkg::REG_INTERVAL, 8'h03);
        wr(poll_timer_pkg::REG_PWRMODE, 8'h01);
        rdchk("pwrmode", poll_timer_pkg::REG_PWRMODE, 8'h01);
        for (m = 1; m >= 0; m--)
        begin
            wr(poll_timer_pkg::REG_CLKCON, 8'(m));
            wait_wake(n);
            wait_wake(n);
            check("period", 8'(4 * TC * (m == 1 ? EM : 1)), 8'(n));
        end
        $display("test period done");

        wr(poll_timer_pkg::REG_INTERVAL, 8'd15);
        wait_wake(n);
        repeat (5 * TC) @(negedge ref_clk);
        wr(poll_timer_pkg::REG_INTERVAL, 8'd20);
        wait_wake(n);
        check("raised period", 8'(21 * TC), 8'(5 * TC + 2 + n));
        repeat (8 * TC) @(negedge ref_clk);
        wr(poll_timer_pkg::REG_INTERVAL, 8'd2);
        wait_wake(n);
        check("lowered restart", 8'h01, {7'h00, n >= 2 * TC && n <= 3 * TC + 2});
        $display("test interval change done");

        wr(poll_timer_pkg::REG_INTERVAL, 8'h03);
        walk(8'hd7, 6'h1e, 3);
        walk(8'hab, 6'h29, 3);
        wr(poll_timer_pkg::REG_RXFLAGS, 8'h05);
        walk(8'h03, 6'h05, 2);
        for (m = 0; m < 3; m++)
            walk(8'(m), 6'h05, 0);
        $display("test wake action done");

        // second reset with the strap high: timer must come up running
        reset_state_pin = 1'b1;
        arst_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (6) @(negedge ref_clk);
        rdchk("strap run", poll_timer_pkg::REG_PWRMODE, 8'h01);
        rdchk("interval rst", poll_timer_pkg::REG_INTERVAL, poll_timer_pkg::INTERVAL_RST);
        wr(poll_timer_pkg::REG_INTERVAL, 8'h03);
        wait_wake(n);
        // a low clock enable stretches the period by exactly the frozen cycles
        repeat (TC) @(negedge ref_clk);
        ce = 1'b0;
        repeat (20) @(negedge ref_clk);
        ce = 1'b1;
        wait_wake(n);
        check("frozen period", 8'(4 * TC + 20), 8'(TC + 20 + n));
        $display("test strap and freeze done");
        final_report();
    end
endmodule

`default_nettype wire
